/* design/vmrc_defines.svh */
`ifndef VMRC_DEFINES_SVH
`define VMRC_DEFINES_SVH

// ----------------------------------------
// mode selector values
// ----------------------------------------
`define VMRC_MODE_VL        8'h02
`define VMRC_MODE_PV        8'h03

// ----------------------------------------
// ramp type values
// ----------------------------------------
`define VMRC_RAMP_TRAP      8'h00
`define VMRC_RAMP_JERK      8'h03

// ----------------------------------------
// unit handling
// ----------------------------------------
`define VMRC_UNIT_ONE       32'h0000_0001
`define VMRC_SEC_PER_MIN    64'sh0000_0000_0000_003c
`define VMRC_MS_PER_SEC     64'sh0000_0000_0000_03e8
`define VMRC_REV_MECH       1'b1

// ----------------------------------------
// timing
// ----------------------------------------
`define VMRC_CLK_HZ         125000000
`define VMRC_SAMPLE_US      1000
`define VMRC_SAMPLE_CYC     ((`VMRC_CLK_HZ / 1000000) * `VMRC_SAMPLE_US)

// ----------------------------------------
// reset values
// ----------------------------------------
`define VMRC_ZERO32         32'sh0000_0000
`define VMRC_ZERO16         16'h0000

`endif

/* design/vmrc_pkg.sv */
package vmrc_pkg;

	typedef enum logic [3:0] {
		VMRC_IDLE = 4'b0001,
		VMRC_RUN  = 4'b0010,
		VMRC_HALT = 4'b0100,
		VMRC_QSTP = 4'b1000
	} vmrc_state_t;

	typedef logic signed [31:0] vmrc_speed_t;

endpackage : vmrc_pkg

/* design/vmrc_ramp.sv */
// Functional notes
// R1: sample motor position once every millisecond
// R2: chained relative base uses sample after target
// R3: ramp type 0 plain, 3 jerk limited
// R4: user jerk capped by internal jerk ceiling
// R5: never exceed max accel or max decel; leaving modes 2 and 3 clears demand to zero at once, ignoring max decel
// R6: quick stop brakes with emergency deceleration
// R7: host writes 2 for simple velocity mode
// R8: simple velocity mode uses linear ramps only
// R9: halt stops; edges ramp up or down
// R10: status bit 11 while limit constrains ramp
// R11: speed unit rpm or scaled rev/s
// R12: revolution type electrical or mechanical
// R13: acceleration is speed delta over seconds
// R14: host gives deceleration delta as positive
// R15: target below minimum raised to minimum
// R16: target above maximum cut to maximum
// R17: velocity quick stop ramp has own object
// R18: ramp tracks target within limits, readback
// R19: host writes 3 for profile velocity mode
// R20: profile velocity halt stops and restarts
// R21: bit 10 with halt encodes four states
// R22: reached only after window held window time
// R23: other modes keep this logic idle
// R24: parameter changes apply at next update
`timescale 1ns/1ps
`include "vmrc_defines.svh"
`default_nettype none

module vmrc_ramp
	import vmrc_pkg::*;
#(
	parameter int SAMPLE_CYC = `VMRC_SAMPLE_CYC
) (
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RSTN,
	// mode and control
	input  wire logic [7:0]  MODE_SEL,
	input  wire logic        HALT,
	input  wire logic        QSTOP_ACTIVE,
	input  wire logic [7:0]  RAMP_TYPE,
	// units
	input  wire logic [31:0] DIM_NUM,
	input  wire logic [31:0] DIM_DEN,
	input  wire logic        REV_TYPE,
	input  wire logic [15:0] POLE_PAIRS,
	// velocity mode objects
	input  wire vmrc_speed_t VL_TARGET,
	input  wire vmrc_speed_t VL_MIN,
	input  wire vmrc_speed_t VL_MAX,
	input  wire logic [31:0] SPEED_MODE_ACCEL_DELTA,
	input  wire logic [15:0] SPEED_MODE_ACCEL_SEC,
	input  wire logic [31:0] VL_DECEL_DELTA,
	input  wire logic [15:0] VL_DECEL_SEC,
	input  wire logic [31:0] VL_QSTOP_DELTA,
	input  wire logic [15:0] VL_QSTOP_SEC,
	// profile velocity objects
	input  wire vmrc_speed_t PV_TARGET,
	input  wire logic [31:0] PROF_ACCEL,
	input  wire logic [31:0] PROF_DECEL,
	input  wire logic [31:0] QSTOP_DECEL,
	input  wire logic [31:0] MAX_ACCEL,
	input  wire logic [31:0] MAX_DECEL,
	input  wire logic [31:0] JERK_1,
	input  wire logic [31:0] JERK_2,
	input  wire logic [31:0] JERK_3,
	input  wire logic [31:0] JERK_4,
	input  wire logic [31:0] JERK_CEIL,
	input  wire logic [31:0] VEL_WINDOW,
	input  wire logic [15:0] VEL_WINDOW_MS,
	// motor feedback
	input  wire vmrc_speed_t SPEED_ACTUAL,
	input  wire logic [31:0] POS_ACTUAL,
	input  wire logic        POS_TARGET_HIT,
	input  wire logic        END_VEL_NZ,
	// outputs
	output var  vmrc_speed_t DEMAND,
	output var  vmrc_speed_t ACTUAL_RB,
	output logic             STAT_REACHED,
	output logic             STAT_LIMIT,
	output logic             STAT_VALID,
	output logic [31:0]      POS_SAMPLE,
	output logic [31:0]      POS_BASE,
	output logic             POS_BASE_VALID
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// user speed to internal rpm
	function automatic logic signed [31:0] to_int(input logic signed [31:0] v,
		input logic [31:0] n, input logic [31:0] d, input logic mech,
		input logic [15:0] pp);
		logic signed [63:0] t;
		t = 64'(v);
		if (!(n == `VMRC_UNIT_ONE && d == `VMRC_UNIT_ONE) && n != 32'h0) // R11
			t = (t * `VMRC_SEC_PER_MIN * $signed({32'h0, d})) / $signed({32'h0, n});
		if (mech != `VMRC_REV_MECH && pp != `VMRC_ZERO16) // R12
			t = t / $signed({48'h0, pp});
		return t[31:0];
	endfunction : to_int

	// delta per second to per-millisecond step
	function automatic logic [31:0] rate(input logic [31:0] dlt, input logic [15:0] sec);
		logic [63:0] t;
		t = {32'h0, dlt};
		if (sec != `VMRC_ZERO16) // R13
			t = t / ({48'h0, sec} * 64'(`VMRC_MS_PER_SEC));
		if (t == 64'h0 && dlt != 32'h0)
			t = 64'h1;
		return t[31:0];
	endfunction : rate

	function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
		return (a < b) ? a : b;
	endfunction : umin

	function automatic logic [31:0] sabs(input logic signed [31:0] a);
		return (a < 0) ? 32'(-a) : 32'(a);
	endfunction : sabs

	// ----------------------------------------
	// millisecond tick and position sampling
	// ----------------------------------------
	logic [31:0] tick_cnt_q, tick_cnt_d;
	logic        tick;
	logic [31:0] pos_smp_q, pos_smp_d, pos_base_q, pos_base_d;
	logic        base_pend_q, base_pend_d, base_vld_q, base_vld_d;
	assign tick = (tick_cnt_q == 32'(SAMPLE_CYC - 1));

	always_comb begin
		tick_cnt_d  = tick ? 32'h0 : tick_cnt_q + 32'h1;
		pos_smp_d   = tick ? POS_ACTUAL : pos_smp_q; // R1
		pos_base_d  = pos_base_q;
		base_pend_d = base_pend_q;
		base_vld_d  = 1'b0;
		if (POS_TARGET_HIT && END_VEL_NZ)
			base_pend_d = 1'b1;
		if (tick && (base_pend_q || (POS_TARGET_HIT && END_VEL_NZ))) begin
			pos_base_d  = POS_ACTUAL; // R2
			base_pend_d = 1'b0;
			base_vld_d  = 1'b1;
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			tick_cnt_q  <= 32'h0;
			pos_smp_q   <= 32'h0;
			pos_base_q  <= 32'h0;
			base_pend_q <= 1'b0;
			base_vld_q  <= 1'b0;
		end else begin
			tick_cnt_q  <= tick_cnt_d;
			pos_smp_q   <= pos_smp_d;
			pos_base_q  <= pos_base_d;
			base_pend_q <= base_pend_d;
			base_vld_q  <= base_vld_d;
		end
	end

	// ----------------------------------------
	// target selection and limits
	// ----------------------------------------
	logic        is_vl, is_pv, jerk_on;
	vmrc_speed_t tgt_raw, tgt, vmin, vmax;
	logic        clamped;
	logic [31:0] up_rate, dn_rate, jk_up, jk_dn;
	always_comb begin
		is_vl   = (MODE_SEL == `VMRC_MODE_VL); // R7
		is_pv   = (MODE_SEL == `VMRC_MODE_PV); // R19
		jerk_on = is_pv && (RAMP_TYPE == `VMRC_RAMP_JERK); // R3 R8
		vmin    = to_int(VL_MIN, DIM_NUM, DIM_DEN, REV_TYPE, POLE_PAIRS);
		vmax    = to_int(VL_MAX, DIM_NUM, DIM_DEN, REV_TYPE, POLE_PAIRS);
		tgt_raw = is_vl ? to_int(VL_TARGET, DIM_NUM, DIM_DEN, REV_TYPE, POLE_PAIRS)
		                : PV_TARGET;
		tgt     = tgt_raw;
		clamped = 1'b0;
		if (is_vl && tgt_raw < vmin) begin
			tgt     = vmin; // R15
			clamped = 1'b1;
		end else if (is_vl && tgt_raw > vmax) begin
			tgt     = vmax; // R16
			clamped = 1'b1;
		end
		// R24 rates follow the inputs live, picked up at the next tick
		if (is_vl) begin
			up_rate = rate(SPEED_MODE_ACCEL_DELTA, SPEED_MODE_ACCEL_SEC); // R13
			dn_rate = rate(VL_DECEL_DELTA, VL_DECEL_SEC); // R14
			if (QSTOP_ACTIVE)
				dn_rate = rate(VL_QSTOP_DELTA, VL_QSTOP_SEC); // R17
		end else begin
			up_rate = PROF_ACCEL;
			dn_rate = QSTOP_ACTIVE ? QSTOP_DECEL : PROF_DECEL; // R6
		end
		up_rate = umin(up_rate, MAX_ACCEL); // R5
		dn_rate = umin(dn_rate, MAX_DECEL); // R5
		jk_up   = umin(umin(JERK_1, JERK_2), JERK_CEIL); // R4
		jk_dn   = umin(umin(JERK_3, JERK_4), JERK_CEIL); // R4
	end

	// ----------------------------------------
	// ramp generator
	// ----------------------------------------
	vmrc_state_t st_q, st_d;
	vmrc_speed_t dem_q, dem_d, acc_q, acc_d, act_q, act_d;
	logic        lim_q, lim_d;
	vmrc_speed_t goal, diff, step, lim_rate, acc_goal, acc_n;
	logic        up;
	always_comb begin
		st_d  = st_q;
		dem_d = dem_q;
		acc_d = acc_q;
		act_d = SPEED_ACTUAL; // R18
		lim_d = lim_q && is_vl; // R10
		case (st_q)
			VMRC_IDLE: st_d = VMRC_IDLE;
			VMRC_RUN:  st_d = VMRC_RUN;
			VMRC_HALT: st_d = VMRC_HALT;
			VMRC_QSTP: st_d = VMRC_QSTP;
			default:   st_d = VMRC_IDLE;
		endcase
		if (!(is_vl || is_pv))
			st_d = VMRC_IDLE; // R23
		else if (QSTOP_ACTIVE)
			st_d = VMRC_QSTP; // R6
		else if (HALT)
			st_d = VMRC_HALT; // R9 R20
		else
			st_d = VMRC_RUN;
		goal = (st_d == VMRC_RUN) ? tgt : `VMRC_ZERO32;
		diff = goal - dem_q;
		up   = (dem_q >= 0) ? (diff > 0) : (diff < 0);
		lim_rate = $signed(up ? up_rate : dn_rate);
		acc_goal = (diff > 0) ? lim_rate : -lim_rate;
		if (jerk_on) begin
			if (acc_q < acc_goal)
				acc_n = (acc_goal - acc_q > $signed(jk_up)) ? acc_q + $signed(jk_up) : acc_goal;
			else
				acc_n = (acc_q - acc_goal > $signed(jk_dn)) ? acc_q - $signed(jk_dn) : acc_goal;
		end else begin
			acc_n = acc_goal;
		end
		step = (diff == 0) ? `VMRC_ZERO32 : acc_n;
		if (st_d == VMRC_IDLE) begin
			dem_d = `VMRC_ZERO32;
			acc_d = `VMRC_ZERO32;
			lim_d = 1'b0;
		end else if (tick) begin
			if (sabs(diff) <= sabs(step)) begin
				dem_d = goal; // R18
				acc_d = `VMRC_ZERO32;
			end else begin
				dem_d = dem_q + step;
				acc_d = acc_n;
			end
			lim_d = is_vl && (clamped || (sabs(diff) > sabs(step))); // R10
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			st_q  <= VMRC_IDLE;
			dem_q <= `VMRC_ZERO32;
			acc_q <= `VMRC_ZERO32;
			act_q <= `VMRC_ZERO32;
			lim_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			dem_q <= dem_d;
			acc_q <= acc_d;
			act_q <= act_d;
			lim_q <= lim_d;
		end
	end

	// ----------------------------------------
	// target reached window
	// ----------------------------------------
	logic [15:0] win_cnt_q, win_cnt_d;
	logic        reach_q, reach_d, in_win;
	vmrc_speed_t ref_spd;
	always_comb begin
		ref_spd   = HALT ? `VMRC_ZERO32 : dem_q;
		in_win    = sabs(SPEED_ACTUAL - ref_spd) <= VEL_WINDOW;
		win_cnt_d = win_cnt_q;
		reach_d   = reach_q;
		if (!is_pv || !in_win) begin
			win_cnt_d = `VMRC_ZERO16;
			reach_d   = 1'b0;
		end else if (HALT && dem_q != 0) begin
			win_cnt_d = `VMRC_ZERO16; // R21
			reach_d   = 1'b0;
		end else if (!HALT && dem_q != tgt) begin
			win_cnt_d = `VMRC_ZERO16;
			reach_d   = 1'b0;
		end else if (tick) begin
			if (win_cnt_q >= VEL_WINDOW_MS)
				reach_d = 1'b1; // R22
			else
				win_cnt_d = win_cnt_q + 16'h1;
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			win_cnt_q <= `VMRC_ZERO16;
			reach_q   <= 1'b0;
		end else begin
			win_cnt_q <= win_cnt_d;
			reach_q   <= reach_d;
		end
	end

	// ----------------------------------------
	// outputs, all registered
	// ----------------------------------------
	logic valid_q;
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN)
			valid_q <= 1'b0;
		else
			valid_q <= is_vl || is_pv; // R23
	end

	assign DEMAND         = dem_q;
	assign ACTUAL_RB      = act_q;
	assign STAT_REACHED   = reach_q; // R21
	assign STAT_LIMIT     = lim_q; // R10
	assign STAT_VALID     = valid_q;
	assign POS_SAMPLE     = pos_smp_q;
	assign POS_BASE       = pos_base_q;
	assign POS_BASE_VALID = base_vld_q;

endmodule : vmrc_ramp

`default_nettype wire

/* tb/vmrc_ramp_asserts.sv */
`timescale 1ns/1ps
`include "vmrc_defines.svh"
`default_nettype none

module vmrc_ramp_asserts
	import vmrc_pkg::*;
#(
	parameter int SAMPLE_CYC = 10
) (
	// clock and reset
	input wire logic        MCLK,
	input wire logic        RSTN,
	// stimulus
	input wire logic [7:0]  MODE_SEL,
	input wire logic        HALT,
	input wire vmrc_speed_t VL_TARGET,
	input wire vmrc_speed_t VL_MAX,
	input wire logic [31:0] DIM_NUM,
	input wire logic [31:0] DIM_DEN,
	input wire logic        REV_TYPE,
	input wire logic [15:0] POLE_PAIRS,
	input wire logic [31:0] MAX_ACCEL,
	input wire logic [31:0] MAX_DECEL,
	input wire logic [31:0] POS_ACTUAL,
	input wire logic        POS_TARGET_HIT,
	input wire logic        END_VEL_NZ,
	// results
	input wire vmrc_speed_t DEMAND,
	input wire logic        STAT_REACHED,
	input wire logic        STAT_LIMIT,
	input wire logic        STAT_VALID,
	input wire logic [31:0] POS_SAMPLE,
	input wire logic [31:0] POS_BASE,
	input wire logic        POS_BASE_VALID
);
	// ----------------------------------------
	// millisecond tick mirror
	// ----------------------------------------
	int   cnt_q;
	int   cnt_d;
	logic tick;
	logic vl;
	logic pv;
	logic run;
	assign tick = cnt_q == SAMPLE_CYC - 1;
	assign vl = MODE_SEL == `VMRC_MODE_VL;
	assign pv = MODE_SEL == `VMRC_MODE_PV;
	assign run = vl || pv;
	always_comb begin
		cnt_d = tick ? 0 : cnt_q + 1;
	end
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) cnt_q <= 0;
		else cnt_q <= cnt_d;
	end

	// ----------------------------------------
	// maximum speed in internal units
	// ----------------------------------------
	logic signed [63:0] vmax_w;
	vmrc_speed_t        vmax_int;
	always_comb begin
		vmax_w = 64'(VL_MAX);
		if ((DIM_NUM != 32'h1 || DIM_DEN != 32'h1) && DIM_NUM != 32'h0)
			vmax_w = vmax_w * 64'sh3c * $signed({32'h0, DIM_DEN}) / $signed({32'h0, DIM_NUM});
		if (!REV_TYPE && POLE_PAIRS != 16'h0)
			vmax_w = vmax_w / $signed({48'h0, POLE_PAIRS});
		vmax_int = vmax_w[31:0];
	end

	default clocking @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	sequence s_hit;
		POS_TARGET_HIT && END_VEL_NZ;
	endsequence
	sequence s_base;
		##[1:25] POS_BASE_VALID;
	endsequence

	a_valid_mode: assert property ($past(RSTN) |-> STAT_VALID == $past(run))
		else $error("valid flag does not follow mode");
	a_idle_out: assert property (!run |=> DEMAND == 0 && !STAT_REACHED && !STAT_LIMIT)
		else $error("idle mode left outputs active");
	a_demand_tick: assert property ($past(RSTN) && !$stable(DEMAND) |-> $past(tick) || !$past(run))
		else $error("demand moved off the tick");
	a_sample_tick: assert property (tick |=> POS_SAMPLE == $past(POS_ACTUAL))
		else $error("position sample not taken at tick");
	a_base_pulse: assert property (s_hit |-> s_base)
		else $error("no base pulse after target hit");
	a_base_value: assert property (POS_BASE_VALID |-> POS_BASE == POS_SAMPLE ##1 !POS_BASE_VALID)
		else $error("base differs from sample or pulse too long");
	a_step_bound: assert property (pv && $past(pv) |-> $signed(DEMAND - $past(DEMAND))
		<= $signed(MAX_ACCEL) && $signed($past(DEMAND) - DEMAND) <= $signed(MAX_DECEL))
		else $error("ramp step beyond acceleration bounds");
	a_vl_max: assert property (vl && $past(vl) |-> DEMAND <= vmax_int)
		else $error("demand above maximum speed");
	a_limit_flag: assert property (vl && tick && !HALT && VL_TARGET > VL_MAX |=> STAT_LIMIT)
		else $error("limit flag low while clamped");
	a_halt_reach: assert property (pv && HALT && $past(HALT) && STAT_REACHED |-> DEMAND == 0)
		else $error("standstill flag with demand running");
endmodule : vmrc_ramp_asserts

bind vmrc_ramp vmrc_ramp_asserts #(.SAMPLE_CYC(SAMPLE_CYC)) vmrc_ramp_asserts_inst (
	.MCLK(MCLK), .RSTN(RSTN), .MODE_SEL(MODE_SEL), .HALT(HALT), .VL_TARGET(VL_TARGET),
	.VL_MAX(VL_MAX), .DIM_NUM(DIM_NUM), .DIM_DEN(DIM_DEN), .REV_TYPE(REV_TYPE),
	.POLE_PAIRS(POLE_PAIRS), .MAX_ACCEL(MAX_ACCEL), .MAX_DECEL(MAX_DECEL), .POS_ACTUAL(POS_ACTUAL),
	.POS_TARGET_HIT(POS_TARGET_HIT), .END_VEL_NZ(END_VEL_NZ), .DEMAND(DEMAND),
	.STAT_REACHED(STAT_REACHED), .STAT_LIMIT(STAT_LIMIT), .STAT_VALID(STAT_VALID),
	.POS_SAMPLE(POS_SAMPLE), .POS_BASE(POS_BASE), .POS_BASE_VALID(POS_BASE_VALID));

`default_nettype wire

/* tb/vmrc_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none

module vmrc_motor_model
	import vmrc_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        RSTN,
	input  wire vmrc_speed_t DEMAND,
	output var  vmrc_speed_t SPEED_ACTUAL,
	output logic [31:0]      POS_ACTUAL,
	output logic             POS_TARGET_HIT
);
	// shaft follows demand one cycle late, target crossed every 64 cycles
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			SPEED_ACTUAL <= '0;
			POS_ACTUAL <= 32'h0;
			POS_TARGET_HIT <= 1'b0;
		end else begin
			SPEED_ACTUAL <= DEMAND;
			POS_ACTUAL <= POS_ACTUAL + 32'h1;
			POS_TARGET_HIT <= POS_ACTUAL[5:0] == 6'h25;
		end
	end
endmodule : vmrc_motor_model

`default_nettype wire

/* tb/vmrc_ramp_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module vmrc_ramp_tb
	import vmrc_pkg::*;
;
	logic        clk = 1'b0, rst_n = 1'b0, hlt = 1'b0, qs = 1'b0, env = 1'b0;
	logic [7:0]  md = 8'h00, rt = 8'h03;
	vmrc_speed_t vt = 32'sh5, vmin = 32'sh2, vmax = 32'sh3, pt = 32'sh14, spd, dem, arb;
	logic [15:0] as_s = 16'h1, ds = 16'h1, qsec = 16'h1, vwt = 16'h2;
	logic [31:0] ad = 32'h7d0, dd = 32'h3e8, qd = 32'h3e8, pa = 32'h4, pd = 32'h5, qdec = 32'h4;
	logic [31:0] mxa = 32'h3, mxd = 32'h5, j1 = 32'h2, j2 = 32'h2, j3 = 32'h2, j4 = 32'h2;
	logic [31:0] jc = 32'h1, vw = 32'h1, pos, psmp, pbase, p;
	logic        hit, reach, lim, val, pbv;
	logic [31:0] dnum = 32'h1, dden = 32'h1;
	logic [15:0] npp = 16'h1;
	logic        rty = 1'b1;
	int          n_fail = 0, n_checks = 0;

	vmrc_ramp #(.SAMPLE_CYC(10)) vmrc_ramp_inst (
		.MCLK(clk), .RSTN(rst_n), .MODE_SEL(md), .HALT(hlt), .QSTOP_ACTIVE(qs), .RAMP_TYPE(rt),
		.DIM_NUM(dnum), .DIM_DEN(dden), .REV_TYPE(rty), .POLE_PAIRS(npp), .VL_TARGET(vt),
		.VL_MIN(vmin), .VL_MAX(vmax), .SPEED_MODE_ACCEL_DELTA(ad), .SPEED_MODE_ACCEL_SEC(as_s),
		.VL_DECEL_DELTA(dd), .VL_DECEL_SEC(ds), .VL_QSTOP_DELTA(qd), .VL_QSTOP_SEC(qsec),
		.PV_TARGET(pt), .PROF_ACCEL(pa), .PROF_DECEL(pd), .QSTOP_DECEL(qdec), .MAX_ACCEL(mxa),
		.MAX_DECEL(mxd), .JERK_1(j1), .JERK_2(j2), .JERK_3(j3), .JERK_4(j4), .JERK_CEIL(jc),
		.VEL_WINDOW(vw), .VEL_WINDOW_MS(vwt), .SPEED_ACTUAL(spd), .POS_ACTUAL(pos),
		.POS_TARGET_HIT(hit), .END_VEL_NZ(env), .DEMAND(dem), .ACTUAL_RB(arb),
		.STAT_REACHED(reach), .STAT_LIMIT(lim), .STAT_VALID(val), .POS_SAMPLE(psmp),
		.POS_BASE(pbase), .POS_BASE_VALID(pbv));
	vmrc_motor_model vmrc_motor_model_inst (.MCLK(clk), .RSTN(rst_n), .DEMAND(dem),
		.SPEED_ACTUAL(spd), .POS_ACTUAL(pos), .POS_TARGET_HIT(hit));

	initial forever #4 clk = ~clk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic summarize;
		if (n_fail == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %0t got %0h want %0h", $time, got, exp);
		end
	endtask : chk
	task automatic ticks(input int n);
		repeat (n * 10) @(posedge clk);
		#1;
	endtask : ticks
	task automatic wait_dem;
		vmrc_speed_t old;
		old = dem;
		for (int i = 0; i < 30 && dem === old; i++) begin
			@(posedge clk);
			#1;
		end
		if (dem === old) begin
			n_fail++;
			$display("unexpected %0t demand stuck", $time);
			summarize;
		end
	endtask : wait_dem

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_vl;
		md = 8'h02;
		wait_dem;
		chk(dem, 32'h2);
		ticks(4);
		chk(dem, 32'h3);
		chk(lim, 32'h1);
		chk(val, 32'h1);
		vt = 32'sh1;
		ticks(4);
		chk(dem, 32'h2);
		hlt = 1'b1;
		ticks(4);
		chk(dem, 32'h0);
		hlt = 1'b0;
		ticks(3);
		chk(dem, 32'h2);
	endtask : t_vl
	task automatic t_idle;
		md = 8'h00;
		@(posedge clk);
		#1;
		chk(dem, 32'h0);
		chk(val, 32'h0);
		chk(lim, 32'h0);
	endtask : t_idle
	task automatic t_pv;
		md = 8'h03;
		wait_dem;
		chk(dem, 32'h1);
		rt = 8'h00;
		md = 8'h00;
		@(posedge clk);
		#1;
		md = 8'h03;
		wait_dem;
		chk(dem, 32'h3);
		chk(reach, 32'h0);
		ticks(10);
		chk(dem, 32'h14);
		chk(arb, 32'h14);
		chk(reach, 32'h1);
		qs = 1'b1;
		wait_dem;
		chk(dem, 32'h10);
		qs = 1'b0;
		hlt = 1'b1;
		wait_dem;
		chk(dem, 32'hb);
		chk(reach, 32'h0);
		ticks(8);
		chk(reach, 32'h1);
		hlt = 1'b0;
		ticks(10);
		chk(dem, 32'h14);
	endtask : t_pv
	task automatic t_pos;
		env = 1'b1;
		for (int i = 0; i < 100 && pbv !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk(pbv, 32'h1);
		chk(pbase, psmp);
		p = psmp;
		repeat (10) @(posedge clk);
		#1;
		chk(psmp, p + 32'ha);
	endtask : t_pos
	task automatic t_unit;
		md = 8'h00;
		dnum = 32'h2;
		dden = 32'h4;
		vmin = 32'sh0;
		ad = 32'hfa00;
		dd = 32'hfa00;
		mxa = 32'h40;
		mxd = 32'h40;
		ticks(1);
		md = 8'h02;
		ticks(3);
		chk(dem, 32'h78);
		md = 8'h00;
		rty = 1'b0;
		npp = 16'h4;
		ticks(1);
		md = 8'h02;
		ticks(2);
		chk(dem, 32'h1e);
	endtask : t_unit

	initial begin
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_vl;
		t_idle;
		t_pv;
		t_pos;
		t_unit;
		summarize;
	end
endmodule : vmrc_ramp_tb

`default_nettype wire
